// *** hw/ccmd_interpreter.sv ***
// command interpreter, bus slave and configuration store of the compass
// assumes sclIn/sdaIn already synchronous to core_clk; sdaOe pulls the wire
`timescale 1ns/1ps
`default_nettype none

// Contract
// - address byte stored even, 0x10 to 0xF6
// - new address used after reset only
// - mount correction added to heading
// - mount correction sixteen bit at 0x0B/0x0A
// - declination added for true north
// - declination sixteen bit at 0x0D/0x0C
// - field = raw plus both offset sets
// - hard-iron bytes 0x0E-0x13, loaded into the working copy by the 0x82 reset command
// - calibration end overwrites hard-iron bytes
// - heading smoothing only in run mode
// - heading 0-3600, tilt within 900
// - write transfer: command then arguments
// - read bytes follow last known command only
// - every command byte acknowledged
// - 0x40 accel, 0x45 field, six bytes
// - 0x50 heading set, 0x55 tilt set
// - 0x65 returns first mode byte; bit 7 here reports the run bit
// - 0x71 enter, 0x7E leave calibration
// - 0x72-0x74 select mounting orientation
// - 0x75 run, 0x76 standby
// - 0x83 sleep, 0x84 wake to standby
// - 0xE1 reads, 0xF1 writes one byte
module ccmd_interpreter
   import ccmd_pkg::*;
#(
   parameter logic [7:0] FW_REV = 8'h01, // arbitrary value
   parameter logic [7:0] SERIAL_LO = 8'h00, // arbitrary value
   parameter logic [7:0] SERIAL_HI = 8'h00, // arbitrary value
   parameter logic [7:0] BUILD_YEAR = 8'h00, // arbitrary value
   parameter logic [7:0] BUILD_WEEK = 8'h00 // arbitrary value
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire ccmd_sensor_s sensor,
   input wire ccmd_calib_s calib,
   output ccmd_status_s status
);

   typedef logic [CFG_DEPTH-1:0][7:0] ccmd_cfg_t;

   function automatic ccmd_cfg_t initCfg();
      ccmd_cfg_t c;
      c = '0;
      c[OFS_BUS_ADDR] = RST_BUS_ADDR;
      c[OFS_FW_REV] = FW_REV;
      c[OFS_MODE_FIRST] = RST_MODE_FIRST;
      c[OFS_MODE_SECOND] = RST_MODE_SECOND;
      c[OFS_SERIAL_LO] = SERIAL_LO;
      c[OFS_SERIAL_HI] = SERIAL_HI;
      c[OFS_BUILD_YEAR] = BUILD_YEAR;
      c[OFS_BUILD_WEEK] = BUILD_WEEK;
      return c;
   endfunction : initCfg

   localparam ccmd_cfg_t CFG_INIT = initCfg();

   function automatic logic signed [16:0] wrapHead(input logic signed [16:0] v);
      logic signed [16:0] r;
      r = v;
      if (v < 17'sh00000)
         r = v + HEAD_FULL;
      else if (v >= HEAD_FULL)
         r = v - HEAD_FULL;
      return r;
   endfunction : wrapHead

   function automatic logic signed [15:0] clampTilt(input logic signed [15:0] v);
      logic signed [15:0] r;
      r = v;
      if (v > TILT_MAX)
         r = TILT_MAX;
      else if (v < -TILT_MAX)
         r = -TILT_MAX;
      return r;
   endfunction : clampTilt

   ccmd_bus_e state_q, state_d;
   logic sclPrev_q, sdaPrev_q;
   logic [3:0] bitCnt_q, bitCnt_d;
   logic [7:0] shift_q, shift_d;
   logic isRead_q, isRead_d, ack_q, ack_d, mAck_q, mAck_d;
   logic wrPend_q, wrPend_d;
   logic [1:0] byteCnt_q, byteCnt_d;
   logic [7:0] cmd_q, cmd_d, arg1_q, arg1_d, arg2_q, arg2_d;
   logic [5:0][7:0] resp_q, resp_d;
   logic [2:0] respLen_q, respLen_d, respIdx_q, respIdx_d;
   ccmd_cfg_t cfg_q, cfg_d;
   logic [7:0] mode_q, mode_d, busAddr_q, busAddr_d;
   logic [2:0][15:0] hiWork_q, hiWork_d;
   logic signed [15:0] fx_q, fy_q, fz_q, head_q, pitch_q, roll_q;

   ////////////////////////////////////////////////////////////////////////
   // bus conditions and decode

   // edges and start/stop while the clock is high
   wire sclRise = sclIn & ~sclPrev_q;
   wire sclFall = ~sclIn & sclPrev_q;
   wire startCond = sclIn & sclPrev_q & sdaPrev_q & ~sdaIn;
   wire stopCond = sclIn & sclPrev_q & ~sdaPrev_q & sdaIn;
   wire addrMatch = shift_q[7:1] == busAddr_q[7:1];
   wire execNow = (startCond | stopCond) & wrPend_q;
   wire hasArg1 = byteCnt_q >= 2'h2;
   wire hasArg2 = byteCnt_q == BYTE_LIMIT;
   wire [4:0] arg1Idx = arg1_q[4:0];
   wire arg1InRange = arg1_q < 8'(CFG_DEPTH);
   wire [7:0] cfgRdByte = arg1InRange ? cfg_q[arg1Idx] : 8'h00;
   wire [2:0] txSel = 3'h5 - respIdx_q;
   wire [7:0] txByte = (respIdx_q < respLen_q) ? resp_q[txSel] : 8'h00;

   // command classes
   wire cmdKnown = cmd_q inside {CMD_ACCEL, CMD_FIELD, CMD_HEAD, CMD_TILT,
      CMD_MODE, CMD_CAL_ON, CMD_LEVEL, CMD_EDGE, CMD_FRONT, CMD_RUN,
      CMD_STBY, CMD_CAL_OFF, CMD_RESET, CMD_SLEEP, CMD_WAKE, CMD_CFG_RD,
      CMD_CFG_WR};
   wire addrLegal = arg2_q >= ADDR_MIN && arg2_q <= ADDR_MAX && !arg2_q[0];
   wire hostWritable = arg1_q == OFS_BUS_ADDR || arg1_q == OFS_MODE_FIRST ||
      arg1_q == OFS_MODE_SECOND || (arg1_q >= OFS_MOUNT_LO &&
      arg1_q <= OFS_SMOOTH_HI);
   wire cfgWrite = execNow && cmd_q == CMD_CFG_WR && hasArg2 && hostWritable &&
      (arg1_q != OFS_BUS_ADDR || addrLegal);
   wire [7:0] modeReport = {mode_q[M1_RUN], mode_q[6:0]};

   // open-drain data: ack or a low data bit pulls the wire
   assign sdaOut = 1'b0;
   assign sdaOe = (state_q == ST_ACK && ack_q) ||
      (state_q == ST_READ && !shift_q[7]);

   ////////////////////////////////////////////////////////////////////////
   // bus slave state machine

   always_comb
   begin
      state_d = state_q;
      bitCnt_d = bitCnt_q;
      shift_d = shift_q;
      isRead_d = isRead_q;
      ack_d = ack_q;
      mAck_d = mAck_q;
      wrPend_d = wrPend_q;
      byteCnt_d = byteCnt_q;
      cmd_d = cmd_q;
      arg1_d = arg1_q;
      arg2_d = arg2_q;
      respIdx_d = respIdx_q;
      if (startCond || stopCond)
      begin
         state_d = startCond ? ST_ADDR : ST_IDLE;
         bitCnt_d = 4'h0;
         byteCnt_d = 2'h0;
         wrPend_d = 1'b0;
         ack_d = 1'b0;
      end
      else
      begin
         case (state_q)
            ST_ADDR, ST_WRITE:
            begin
               if (sclRise && bitCnt_q < BIT_LAST)
               begin
                  shift_d = {shift_q[6:0], sdaIn};
                  bitCnt_d = bitCnt_q + 4'h1;
               end
               else if (sclFall && bitCnt_q == BIT_LAST)
               begin
                  bitCnt_d = 4'h0;
                  state_d = ST_ACK;
                  if (state_q == ST_ADDR)
                  begin
                     ack_d = addrMatch;
                     isRead_d = shift_q[0];
                     respIdx_d = 3'h0;
                     if (!addrMatch)
                        state_d = ST_IDLE;
                  end
                  else
                  begin
                     // first byte is the command, up to two arguments follow
                     ack_d = byteCnt_q != BYTE_LIMIT;
                     if (byteCnt_q != BYTE_LIMIT)
                     begin
                        byteCnt_d = byteCnt_q + 2'h1;
                        wrPend_d = 1'b1;
                     end
                     case (byteCnt_q)
                        2'h0: cmd_d = shift_q;
                        2'h1: arg1_d = shift_q;
                        2'h2: arg2_d = shift_q;
                        default: ;
                     endcase
                  end
               end
            end
            ST_ACK:
            begin
               if (sclFall)
               begin
                  ack_d = 1'b0;
                  state_d = isRead_q ? ST_READ : ST_WRITE;
                  if (isRead_q)
                  begin
                     shift_d = txByte;
                     respIdx_d = (respIdx_q == 3'h7) ? respIdx_q : respIdx_q + 3'h1;
                  end
               end
            end
            ST_READ:
            begin
               if (sclRise)
                  bitCnt_d = bitCnt_q + 4'h1;
               else if (sclFall && bitCnt_q == BIT_LAST)
               begin
                  state_d = ST_MACK;
                  bitCnt_d = 4'h0;
               end
               else if (sclFall)
                  shift_d = {shift_q[6:0], 1'b1};
            end
            ST_MACK:
            begin
               if (sclRise)
                  mAck_d = ~sdaIn;
               else if (sclFall && mAck_q)
               begin
                  state_d = ST_READ;
                  shift_d = txByte;
                  respIdx_d = (respIdx_q == 3'h7) ? respIdx_q : respIdx_q + 3'h1;
               end
               else if (sclFall)
                  state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command execution

   // mode, live address and working hard-iron copy
   always_comb
   begin
      mode_d = mode_q;
      busAddr_d = busAddr_q;
      hiWork_d = hiWork_q;
      if (execNow)
      begin
         case (cmd_q)
            CMD_RESET:
            begin
               mode_d = cfg_q[OFS_MODE_FIRST] & 8'h3F;
               busAddr_d = cfg_q[OFS_BUS_ADDR];
               hiWork_d = cfg_q[19:14];
            end
            CMD_CAL_ON: mode_d[M1_CAL] = 1'b1;
            CMD_CAL_OFF: mode_d[M1_CAL] = 1'b0;
            CMD_LEVEL: mode_d[2:0] = ORIENT_LEVEL;
            CMD_EDGE: mode_d[2:0] = ORIENT_EDGE;
            CMD_FRONT: mode_d[2:0] = ORIENT_FRONT;
            CMD_RUN:
               if (mode_q[M1_STBY])
                  mode_d[M1_RUN:M1_STBY] = 2'b10;
            CMD_STBY:
               if (mode_q[M1_RUN])
                  mode_d[M1_RUN:M1_STBY] = 2'b01;
            CMD_SLEEP:
               if (mode_q[M1_RUN])
                  mode_d[M1_RUN:M1_STBY] = 2'b00;
            CMD_WAKE:
               if (mode_q[M1_RUN:M1_STBY] == 2'b00)
                  mode_d[M1_RUN:M1_STBY] = 2'b01;
            default: ;
         endcase
      end
      if (calib.valid)
         hiWork_d = {calib.offZ, calib.offY, calib.offX};
   end

   // configuration store; calibration result wins over a host write
   always_comb
   begin
      cfg_d = cfg_q;
      if (cfgWrite)
         cfg_d[arg1Idx] = arg2_q;
      if (calib.valid)
         cfg_d[19:14] = {calib.offZ, calib.offY, calib.offX};
   end

   // response snapshot taken when the command executes
   always_comb
   begin
      resp_d = resp_q;
      respLen_d = respLen_q;
      if (execNow && cmdKnown)
      begin
         respLen_d = 3'h0;
         case (cmd_q)
            CMD_ACCEL:
            begin
               resp_d = {sensor.accX, sensor.accY, sensor.accZ};
               respLen_d = RESP_SIX;
            end
            CMD_FIELD:
            begin
               resp_d = {fx_q, fy_q, fz_q};
               respLen_d = RESP_SIX;
            end
            CMD_HEAD:
            begin
               resp_d = {head_q, pitch_q, roll_q};
               respLen_d = RESP_SIX;
            end
            CMD_TILT:
            begin
               resp_d = {pitch_q, roll_q, sensor.temp};
               respLen_d = RESP_SIX;
            end
            CMD_MODE:
            begin
               resp_d = {modeReport, 40'h0000000000};
               respLen_d = RESP_ONE;
            end
            CMD_CFG_RD:
            begin
               resp_d = {cfgRdByte, 40'h0000000000};
               respLen_d = hasArg1 ? RESP_ONE : 3'h0;
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // heading, tilt and field compensation

   // sixteen-bit two's complement angles from the store
   wire signed [15:0] mountAng = {cfg_q[OFS_MOUNT_HI], cfg_q[OFS_MOUNT_LO]};
   wire signed [15:0] declAng = {cfg_q[OFS_DECL_HI], cfg_q[OFS_DECL_LO]};
   wire signed [16:0] headSum = 17'(sensor.heading) + 17'(mountAng) +
      17'(declAng);
   wire signed [16:0] headTrue = wrapHead(wrapHead(headSum));
   // smoothing weight; near the 0/3600 seam the filter lags the wrap
   wire [3:0] smoothSh = (cfg_q[OFS_SMOOTH_LO] > 8'(SMOOTH_MAX)) ?
      SMOOTH_MAX : cfg_q[OFS_SMOOTH_LO][3:0];
   wire signed [16:0] headDiff = headTrue - 17'(head_q);
   wire signed [16:0] headStep = headDiff >>> smoothSh;
   wire signed [15:0] headFilt = head_q + headStep[15:0];
   wire filterOn = mode_q[M1_RUN] && mode_q[M1_FILT];

   ////////////////////////////////////////////////////////////////////////
   // registers

   // bus sampling and transfer state
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         sclPrev_q <= 1'b1;
         sdaPrev_q <= 1'b1;
         bitCnt_q <= 4'h0;
         shift_q <= 8'hFF;
         {isRead_q, ack_q, mAck_q, wrPend_q} <= 4'h0;
         byteCnt_q <= 2'h0;
         {cmd_q, arg1_q, arg2_q} <= 24'h000000;
         respIdx_q <= 3'h0;
      end
      else
      begin
         state_q <= state_d;
         sclPrev_q <= sclIn;
         sdaPrev_q <= sdaIn;
         bitCnt_q <= bitCnt_d;
         shift_q <= shift_d;
         {isRead_q, ack_q, mAck_q, wrPend_q} <= {isRead_d, ack_d, mAck_d, wrPend_d};
         byteCnt_q <= byteCnt_d;
         {cmd_q, arg1_q, arg2_q} <= {cmd_d, arg1_d, arg2_d};
         respIdx_q <= respIdx_d;
      end
   end

   // store and mode; power-up loads the defaults everywhere
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_q <= CFG_INIT;
         mode_q <= RST_MODE_FIRST;
         busAddr_q <= RST_BUS_ADDR;
         hiWork_q <= '0;
         resp_q <= '0;
         respLen_q <= 3'h0;
      end
      else
      begin
         cfg_q <= cfg_d;
         mode_q <= mode_d;
         busAddr_q <= busAddr_d;
         hiWork_q <= hiWork_d;
         resp_q <= resp_d;
         respLen_q <= respLen_d;
      end
   end

   // computed outputs, refreshed on each sensor sample
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         {fx_q, fy_q, fz_q, head_q, pitch_q, roll_q} <= '0;
      else if (sensor.valid)
      begin
         fx_q <= sensor.rawX + sensor.srX + hiWork_q[0];
         fy_q <= sensor.rawY + sensor.srY + hiWork_q[1];
         fz_q <= sensor.rawZ + sensor.srZ + hiWork_q[2];
         head_q <= filterOn ? headFilt : headTrue[15:0];
         pitch_q <= clampTilt(sensor.pitch);
         roll_q <= clampTilt(sensor.roll);
      end
   end

   // status from flops
   assign status = '{fieldX: fx_q, fieldY: fy_q, fieldZ: fz_q, heading: head_q,
      pitch: pitch_q, roll: roll_q, orient: mode_q[2:0], run: mode_q[M1_RUN],
      standby: mode_q[M1_STBY], sleep: mode_q[M1_RUN:M1_STBY] == 2'b00,
      calMode: mode_q[M1_CAL], rate: cfg_q[OFS_MODE_SECOND][1:0]};

   ////////////////////////////////////////////////////////////////////////
   // checks

   addr_legal_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      cfg_q[0] >= ADDR_MIN && cfg_q[0] <= ADDR_MAX && !cfg_q[0][0])
      else $error("stored bus address out of range");
   addr_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(execNow && cmd_q == CMD_RESET) |=> $stable(busAddr_q))
      else $error("bus address changed without reset command");
   head_range_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      head_q >= 16'sh0000 && head_q < 16'sh0E10)
      else $error("heading out of range");
   head_sum_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      sensor.valid && !filterOn |=> head_q == $past(headTrue[15:0]))
      else $error("heading not corrected by stored angles");
   ack_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_q == ST_WRITE && sclFall && bitCnt_q == BIT_LAST &&
      byteCnt_q < BYTE_LIMIT |=> sdaOe [*1] ##0 state_q == ST_ACK)
      else $error("command byte not acknowledged");
   run_enter_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      execNow && cmd_q == CMD_RUN && mode_q[M1_STBY] |=> status.run && !status.standby)
      else $error("run mode not entered");
   sleep_enter_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      execNow && cmd_q == CMD_SLEEP && mode_q[M1_RUN] |=> status.sleep)
      else $error("sleep not entered");
   unknown_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      execNow && !cmdKnown && !calib.valid |=> $stable(mode_q) && $stable(cfg_q))
      else $error("unknown command changed state");
   cal_store_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      calib.valid |=> cfg_q[15:14] == $past(calib.offX))
      else $error("calibration result not stored");
   resp_six_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      execNow && cmd_q == CMD_ACCEL |=> respLen_q == RESP_SIX ##1 respLen_q == RESP_SIX)
      else $error("accel response not six bytes");

endmodule : ccmd_interpreter

`default_nettype wire

// *** hw/ccmd_pkg.sv ***
// constants, field layouts and carrier types for the compass command block
// assumes one 250 MHz core clock and bus pins already in that clock domain
package ccmd_pkg;

   localparam int CFG_DEPTH = 22;

   // configuration store locations
   localparam logic [7:0] OFS_BUS_ADDR = 8'h00;
   localparam logic [7:0] OFS_RSVD_ONE = 8'h01;
   localparam logic [7:0] OFS_FW_REV = 8'h02;
   localparam logic [7:0] OFS_RSVD_THREE = 8'h03;
   localparam logic [7:0] OFS_MODE_FIRST = 8'h04;
   localparam logic [7:0] OFS_MODE_SECOND = 8'h05;
   localparam logic [7:0] OFS_SERIAL_LO = 8'h06;
   localparam logic [7:0] OFS_SERIAL_HI = 8'h07;
   localparam logic [7:0] OFS_BUILD_YEAR = 8'h08;
   localparam logic [7:0] OFS_BUILD_WEEK = 8'h09;
   localparam logic [7:0] OFS_MOUNT_LO = 8'h0A;
   localparam logic [7:0] OFS_MOUNT_HI = 8'h0B;
   localparam logic [7:0] OFS_DECL_LO = 8'h0C;
   localparam logic [7:0] OFS_DECL_HI = 8'h0D;
   localparam logic [7:0] OFS_HI_X_LO = 8'h0E;
   localparam logic [7:0] OFS_HI_Z_HI = 8'h13;
   localparam logic [7:0] OFS_SMOOTH_LO = 8'h14;
   localparam logic [7:0] OFS_SMOOTH_HI = 8'h15;

   // reset values and legal address window
   localparam logic [7:0] RST_BUS_ADDR = 8'h32;
   localparam logic [7:0] RST_MODE_FIRST = 8'h11;
   localparam logic [7:0] RST_MODE_SECOND = 8'h01;
   localparam logic [7:0] ADDR_MIN = 8'h10;
   localparam logic [7:0] ADDR_MAX = 8'hF6;

   // command bytes
   localparam logic [7:0] CMD_ACCEL = 8'h40;
   localparam logic [7:0] CMD_FIELD = 8'h45;
   localparam logic [7:0] CMD_HEAD = 8'h50;
   localparam logic [7:0] CMD_TILT = 8'h55;
   localparam logic [7:0] CMD_MODE = 8'h65;
   localparam logic [7:0] CMD_CAL_ON = 8'h71;
   localparam logic [7:0] CMD_LEVEL = 8'h72;
   localparam logic [7:0] CMD_EDGE = 8'h73;
   localparam logic [7:0] CMD_FRONT = 8'h74;
   localparam logic [7:0] CMD_RUN = 8'h75;
   localparam logic [7:0] CMD_STBY = 8'h76;
   localparam logic [7:0] CMD_CAL_OFF = 8'h7E;
   localparam logic [7:0] CMD_RESET = 8'h82;
   localparam logic [7:0] CMD_SLEEP = 8'h83;
   localparam logic [7:0] CMD_WAKE = 8'h84;
   localparam logic [7:0] CMD_CFG_RD = 8'hE1;
   localparam logic [7:0] CMD_CFG_WR = 8'hF1;

   // first operating-mode byte fields
   localparam int M1_COMP = 7;
   localparam int M1_CAL = 6;
   localparam int M1_FILT = 5;
   localparam int M1_RUN = 4;
   localparam int M1_STBY = 3;
   localparam logic [2:0] ORIENT_LEVEL = 3'h1;
   localparam logic [2:0] ORIENT_EDGE = 3'h2;
   localparam logic [2:0] ORIENT_FRONT = 3'h4;

   // angle limits, tenths of a degree
   localparam logic signed [16:0] HEAD_FULL = 17'sh00E10;
   localparam logic signed [15:0] TILT_MAX = 16'sh0384;
   localparam logic [3:0] SMOOTH_MAX = 4'hF;

   // transfer sizes
   localparam logic [2:0] RESP_SIX = 3'h6;
   localparam logic [2:0] RESP_ONE = 3'h1;
   localparam logic [1:0] BYTE_LIMIT = 2'h3;
   localparam logic [3:0] BIT_LAST = 4'h8;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ACK = 3'b010,
      ST_WRITE = 3'b011,
      ST_READ = 3'b100,
      ST_MACK = 3'b101
   } ccmd_bus_e;

   typedef struct packed {
      logic valid;
      logic signed [15:0] accX, accY, accZ;
      logic signed [15:0] rawX, rawY, rawZ;
      logic signed [15:0] srX, srY, srZ;
      logic signed [15:0] heading, pitch, roll, temp;
   } ccmd_sensor_s;

   typedef struct packed {
      logic valid;
      logic signed [15:0] offX, offY, offZ;
   } ccmd_calib_s;

   typedef struct packed {
      logic signed [15:0] fieldX, fieldY, fieldZ;
      logic signed [15:0] heading, pitch, roll;
      logic [2:0] orient;
      logic run, standby, sleep, calMode;
      logic [1:0] rate;
   } ccmd_status_s;

endpackage : ccmd_pkg

// *** bench/ccmd_host.sv ***
// bus master model for the compass command block
// assumes the device pulls the data line through sdaOe; line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module ccmd_host
(
   input wire logic core_clk,
   input wire logic sdaOe,
   output logic sclIn,
   output logic sdaIn,
   output logic rdv,
   output logic [8:0] rd9
);
   logic mLow = 1'b0;
   // wired-and data line, pulled up when nobody pulls
   assign sdaIn = !(mLow || sdaOe);
   initial sclIn = 1'b1;
   initial rdv = 1'b0;
   initial rd9 = 9'h000;
   // wait some edges, then step just off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   // start or repeated start
   task automatic start();
      mLow = 1'b0;
      tick(2);
      sclIn = 1'b1;
      tick(3);
      mLow = 1'b1;
      tick(3);
      sclIn = 1'b0;
      tick(2);
   endtask : start
   task automatic stop();
      mLow = 1'b1;
      tick(2);
      sclIn = 1'b1;
      tick(3);
      mLow = 1'b0;
      tick(3);
   endtask : stop
   // eight data bits plus the acknowledge slot, line level reported
   task automatic xfer(input logic [8:0] o);
      for (int i = 8; i >= 0; i--)
      begin
         mLow = !o[i];
         tick(2);
         sclIn = 1'b1;
         tick(3);
         rd9[i] = sdaIn;
         sclIn = 1'b0;
         tick(2);
      end
      rdv = 1'b1;
      tick(1);
      rdv = 1'b0;
   endtask : xfer
endmodule : ccmd_host
`default_nettype wire

// *** bench/ccmd_interpreter_bench.sv ***
// self-checking bench for the compass command interpreter
// assumes ccmd_host as bus master; calibration input pulsed once
`timescale 1ns/1ps
`default_nettype none
module ccmd_interpreter_bench import ccmd_pkg::*;;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic sclIn, sdaIn, sdaOe, rdv;
   logic [8:0] rd9;
   ccmd_sensor_s sns = '0;
   ccmd_calib_s cal = '0;
   ccmd_status_s status;
   logic [8:0] expQ[$];
   logic [47:0] v;
   logic [14:0] tbl[9] = '{{8'h76, 7'h21}, {8'h75, 7'h41}, {8'h83, 7'h11}, {8'h84, 7'h21},
      {8'h71, 7'h29}, {8'h7E, 7'h21}, {8'h73, 7'h22}, {8'h74, 7'h24}, {8'h72, 7'h21}};
   int seed = 32'hFA461AC9;
   int n_mismatch = 0;
   int cmp_count = 0;
   always #2 core_clk = !core_clk;
   ccmd_interpreter i_ccmd_interpreter (.core_clk(core_clk), .rst_n(rst_n), .sclIn(sclIn),
      .sdaIn(sdaIn), .sdaOut(), .sdaOe(sdaOe), .sensor(sns), .calib(cal), .status(status));
   ccmd_host i_ccmd_host (.core_clk(core_clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn),
      .rdv(rdv), .rd9(rd9));
   task automatic check(input logic [8:0] seen, input logic [8:0] want);
      cmp_count++;
      if (seen !== want)
      begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test
   // host byte out, acknowledge noted unless refused
   task automatic wb(input logic [7:0] d, input logic ack);
      expQ.push_back({d, !ack});
      i_ccmd_host.xfer({d, 1'b1});
   endtask : wb
   task automatic cmd(input logic [7:0] a, input logic [23:0] b, input int n, input logic ack);
      i_ccmd_host.start();
      wb(a, ack);
      for (int i = 0; i < n && ack; i++)
         wb(b[23 - 8 * i -: 8], 1'b1);
      i_ccmd_host.stop();
   endtask : cmd
   // read n bytes, expected from the top of v, last one refused by the host
   task automatic rd(input logic [7:0] a, input int n);
      i_ccmd_host.start();
      wb(a, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         expQ.push_back({v[47 - 8 * i -: 8], i == n - 1});
         i_ccmd_host.xfer({8'hFF, i == n - 1});
      end
      i_ccmd_host.stop();
   endtask : rd
   task automatic pulse();
      sns.valid = 1'b1;
      i_ccmd_host.tick(1);
      sns.valid = 1'b0;
   endtask : pulse
   // every byte on the wire against the oldest note
   always @(posedge core_clk)
      if (rdv)
         check(rd9, expQ.pop_front());
   initial
   begin
      repeat (90000) @(posedge core_clk);
      n_mismatch++;
      end_of_test();
   end
   initial
   begin
      repeat (10) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      i_ccmd_host.tick(2);
      sns.accX = 16'($random(seed));
      sns.accY = 16'($random(seed));
      sns.accZ = 16'($random(seed));
      v = {sns.accX, sns.accY, sns.accZ};
      cmd(8'h32, {CMD_ACCEL, 16'h0000}, 1, 1'b1);
      rd(8'h33, 6);
      sns.heading = 16'h0E0B;
      sns.pitch = 16'($random(seed) % 900);
      sns.roll = 16'($random(seed) % 900);
      sns.temp = 16'($random(seed));
      pulse();
      v = {sns.heading, sns.pitch, sns.roll};
      cmd(8'h32, {CMD_HEAD, 16'h0000}, 1, 1'b1);
      rd(8'h33, 6);
      v = {sns.pitch, sns.roll, sns.temp};
      cmd(8'h32, {CMD_TILT, 16'h0000}, 1, 1'b1);
      rd(8'h33, 6);
      cmd(8'h32, {8'h99, 16'h0000}, 1, 1'b1);
      rd(8'h33, 6);
      v = {8'h91, 40'h0};
      cmd(8'h32, {CMD_MODE, 16'h0000}, 1, 1'b1);
      rd(8'h33, 2);
      cmd(8'h32, {CMD_CFG_WR, OFS_MOUNT_LO, 8'h0A}, 3, 1'b1);
      cmd(8'h32, {CMD_CFG_WR, OFS_DECL_LO, 8'h05}, 3, 1'b1);
      pulse();
      v = {16'h000A, sns.pitch, sns.roll};
      cmd(8'h32, {CMD_HEAD, 16'h0000}, 1, 1'b1);
      rd(8'h33, 6);
      // calibration result, then compensated field and stored offset
      {cal.offX, cal.offY, cal.offZ} = 48'({$random(seed), $random(seed)});
      cal.valid = 1'b1;
      i_ccmd_host.tick(1);
      cal.valid = 1'b0;
      {sns.rawX, sns.rawY, sns.rawZ, sns.srX, sns.srY, sns.srZ} =
         {$random(seed), $random(seed), $random(seed)};
      pulse();
      v = {sns.rawX + sns.srX + cal.offX, sns.rawY + sns.srY + cal.offY,
         sns.rawZ + sns.srZ + cal.offZ};
      cmd(8'h32, {CMD_FIELD, 16'h0000}, 1, 1'b1);
      rd(8'h33, 6);
      v = {cal.offX[7:0], 40'h0};
      cmd(8'h32, {CMD_CFG_RD, OFS_HI_X_LO, 8'h00}, 2, 1'b1);
      rd(8'h33, 1);
      for (int i = 0; i < 9; i++)
      begin
         cmd(8'h32, {tbl[i][14:7], 16'h0000}, 1, 1'b1);
         i_ccmd_host.tick(2);
         check(9'({status.run, status.standby, status.sleep, status.calMode, status.orient}),
            9'(tbl[i][6:0]));
      end
      cmd(8'h32, {CMD_CFG_WR, OFS_BUS_ADDR, 8'h40}, 3, 1'b1);
      cmd(8'h32, {CMD_CFG_WR, OFS_BUS_ADDR, 8'h08}, 3, 1'b1);
      cmd(8'h32, {CMD_CFG_WR, OFS_MODE_FIRST, 8'h31}, 3, 1'b1);
      cmd(8'h32, {CMD_CFG_WR, OFS_SMOOTH_LO, 8'h01}, 3, 1'b1);
      v = {8'h40, 40'h0};
      cmd(8'h32, {CMD_CFG_RD, OFS_BUS_ADDR, 8'h00}, 2, 1'b1);
      rd(8'h33, 1);
      cmd(8'h32, {CMD_RESET, 16'h0000}, 1, 1'b1);
      cmd(8'h32, {CMD_MODE, 16'h0000}, 1, 1'b0);
      v = {8'hB1, 40'h0};
      cmd(8'h40, {CMD_MODE, 16'h0000}, 1, 1'b1);
      rd(8'h41, 1);
      // run with smoothing weight one: halfway from 10 towards 35
      sns.heading = 16'h0014;
      pulse();
      check(9'(status.heading), 9'h016);
      v = {16'h0016, 32'h0};
      cmd(8'h40, {CMD_HEAD, 16'h0000}, 1, 1'b1);
      rd(8'h41, 2);
      end_of_test();
   end
endmodule : ccmd_interpreter_bench
`default_nettype wire
